// [sfm_pkg.sv]
// shared constants and types for the signed fractional multiply datapath
// assumes one core clock; all users reference names as sfm_pkg::name
package sfm_pkg;

  // ==========================================
  // widths
  localparam int WORD_W  = 16;               // operand / word register width
  localparam int ACC_W   = 36;               // extension + middle + low word
  localparam int PTR_N   = 8;                // number of address pointers
  localparam int FRAC_SHIFT = 1;             // binary point alignment shift
  localparam int INSTR_CYCLES = 1;           // cycles per instruction

  // ==========================================
  // operand source codes
  localparam logic [2:0] SRC_X0 = 3'h0;      // first operand register
  localparam logic [2:0] SRC_Y0 = 3'h1;      // second operand register
  localparam logic [2:0] SRC_Y1 = 3'h2;      // third operand register
  localparam logic [2:0] SRC_A1 = 3'h3;      // accumulator a middle word
  localparam logic [2:0] SRC_B1 = 3'h4;      // accumulator b middle word
  localparam logic [2:0] SRC_C1 = 3'h5;      // accumulator c middle word

  // ==========================================
  // destination / move register codes
  localparam logic [2:0] DST_A  = 3'h0;      // accumulator a
  localparam logic [2:0] DST_B  = 3'h1;      // accumulator b
  localparam logic [2:0] DST_C  = 3'h2;      // accumulator c
  localparam logic [2:0] DST_X0 = 3'h3;      // first operand register
  localparam logic [2:0] DST_Y0 = 3'h4;      // second operand register
  localparam logic [2:0] DST_Y1 = 3'h5;      // third operand register

  // ==========================================
  // condition code bit positions
  localparam int CC_C  = 0;                  // carry, untouched here
  localparam int CC_V  = 1;                  // overflow
  localparam int CC_Z  = 2;                  // zero
  localparam int CC_N  = 3;                  // negative
  localparam int CC_U  = 4;                  // unnormalized
  localparam int CC_E  = 5;                  // extension in use
  localparam int CC_L  = 6;                  // limit, sticky
  localparam int CC_SZ = 7;                  // size flag, sticky

  // ==========================================
  // reset and saturation values
  localparam logic [35:0] ACC_RESET  = 36'h0;
  localparam logic [15:0] WORD_RESET = 16'h0;
  localparam logic [7:0]  CC_RESET   = 8'h00;
  localparam logic [15:0] SAT_POS    = 16'h7fff;
  localparam logic [15:0] SAT_NEG    = 16'h8000;
  localparam logic [15:0] LOW_CLEAR  = 16'h0000;

  // ==========================================
  // kinds of parallel memory activity
  typedef enum logic [2:0]
  {
    MOVE_NONE   = 3'b001,
    MOVE_SINGLE = 3'b010,
    MOVE_DUAL   = 3'b100
  } move_kind_t;

  // whole architectural state of the block
  typedef struct packed
  {
    logic [2:0][35:0] acc;                   // a, b, c accumulators
    logic [15:0]      x0;                    // first operand register
    logic [15:0]      y0;                    // second operand register
    logic [15:0]      y1;                    // third operand register
    logic [7:0][15:0] ptr;                   // address pointers
    logic [7:0]       cc;                    // condition codes
  } core_state_t;

endpackage

// [frac_mul_if.sv]
// carrier between the datapath top and its multiplier
// assumes both ends live in the same clock domain
`timescale 1ns/1ps

interface frac_mul_if;
  logic [15:0] opA;                          // first source operand
  logic [15:0] opB;                          // second source operand
  logic        negate;                       // negate one operand
  logic [35:0] product;                      // sign-extended fractional product

  // ==========================================
  // multiplier side
  modport calc
  (
    input  opA,
    input  opB,
    input  negate,
    output product
  );

  // datapath side
  modport user
  (
    output opA,
    output opB,
    output negate,
    input  product
  );
endinterface

// [frac_multiplier.sv]
// combinational signed fractional multiplier
// assumes operands stable within the cycle; no state of its own
`timescale 1ns/1ps

module frac_multiplier
(
  frac_mul_if.calc mul
);

  logic signed [31:0] rawProd;               // integer product
  logic signed [35:0] wideProd;              // sign-extended to accumulator width
  logic signed [35:0] signedProd;            // after optional negation

  // ==========================================
  // product forming
  // product in 36 bits so -1 * -1 keeps its true positive value
  always_comb
  begin
    rawProd    = $signed(mul.opA) * $signed(mul.opB);
    wideProd   = 36'(rawProd);
    // negating the product equals negating one operand, without the -1 overflow
    signedProd = mul.negate ? -wideProd : wideProd;
  end

  // shift left one bit to align the binary point
  assign mul.product = 36'(signedProd <<< sfm_pkg::FRAC_SHIFT);

endmodule

// [signed_fractional_multiply_unit.sv]
// signed fractional multiply execution datapath with parallel moves
// assumes decoder presents one instruction per cycle and memories answer same cycle
//
// Behaviour
// - multiply two 16-bit signed fractions, 32-bit product
// - accumulator destination gets sign-extended product
// - word destination keeps only upper product half
// - negated form only without parallel memory activity
// - extension flag set when extension bits significant
// - negative flag follows result most significant bit
// - zero flag on zero result, overflow cleared
// - limit flag set when parallel move saturates
// - size flag from move, unnormalized from result
// - every form completes in one cycle
// - parallel reads load registers and post-modify pointers
// - previous destination contents never affect result
`timescale 1ns/1ps

module signed_fractional_multiply_unit
(
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                issue,
  input  wire logic [2:0]          src1Sel,
  input  wire logic [2:0]          src2Sel,
  input  wire logic [2:0]          dstSel,
  input  wire logic                negate,
  input  wire sfm_pkg::move_kind_t moveKind,
  input  wire logic                singleIsRead,
  input  wire logic [2:0]          singleSrc,
  input  wire logic                executeFromDataMemory,
  input  wire logic [2:0]          slot0Ptr,
  input  wire logic [15:0]         slot0Step,
  input  wire logic [2:0]          slot0Dst,
  input  wire logic [15:0]         slot0RdData,
  input  wire logic [2:0]          slot1Ptr,
  input  wire logic [15:0]         slot1Step,
  input  wire logic [2:0]          slot1Dst,
  input  wire logic [15:0]         slot1RdData,
  output logic [15:0]              memAddr0,
  output logic [15:0]              memAddr1,
  output logic                     memRdEn0,
  output logic                     memRdEn1,
  output logic                     memWrEn,
  output logic [15:0]              memWrData,
  output logic [35:0]              accA,
  output logic [35:0]              accB,
  output logic [35:0]              accC,
  output logic [15:0]              firstOperand,
  output logic [15:0]              secondOperand,
  output logic [15:0]              thirdOperand,
  output logic [7:0]               conditionCodes
);

  // ==========================================
  // state and helpers
  sfm_pkg::core_state_t st_r;                // registered state
  sfm_pkg::core_state_t st_nxt;              // next state
  frac_mul_if           mul ();              // multiplier carrier
  logic                 isNone;              // no parallel activity
  logic                 isSingle;            // one parallel move
  logic                 isDual;              // two parallel reads allowed
  logic                 singleWrite;         // single move stores to memory
  logic [16:0]          limited;             // {saturated, word} of move source
  logic [35:0]          view;                // result as seen by the flags
  logic [35:0]          moveAcc;             // accumulator feeding a store

  // operand fetch from a source code
  function automatic logic [15:0] operandOf(sfm_pkg::core_state_t s, logic [2:0] sel);
    case (sel)
      sfm_pkg::SRC_X0: operandOf = s.x0;
      sfm_pkg::SRC_Y0: operandOf = s.y0;
      sfm_pkg::SRC_Y1: operandOf = s.y1;
      sfm_pkg::SRC_A1: operandOf = s.acc[0][31:16];
      sfm_pkg::SRC_B1: operandOf = s.acc[1][31:16];
      sfm_pkg::SRC_C1: operandOf = s.acc[2][31:16];
      default:         operandOf = sfm_pkg::WORD_RESET;
    endcase
  endfunction

  // word load into a register; accumulators take it sign-extended, low word cleared
  function automatic sfm_pkg::core_state_t loadWord(sfm_pkg::core_state_t s, logic [2:0] dst,
                                                    logic [15:0] w);
    loadWord = s;
    case (dst)
      sfm_pkg::DST_A:  loadWord.acc[0] = {{4{w[15]}}, w, sfm_pkg::LOW_CLEAR};
      sfm_pkg::DST_B:  loadWord.acc[1] = {{4{w[15]}}, w, sfm_pkg::LOW_CLEAR};
      sfm_pkg::DST_C:  loadWord.acc[2] = {{4{w[15]}}, w, sfm_pkg::LOW_CLEAR};
      sfm_pkg::DST_X0: loadWord.x0 = w;
      sfm_pkg::DST_Y0: loadWord.y0 = w;
      sfm_pkg::DST_Y1: loadWord.y1 = w;
      default:         loadWord = s;
    endcase
  endfunction

  // extension bits in use: bits 35..31 not all equal
  function automatic logic extInUse(logic [35:0] v);
    extInUse = (v[35:31] != {5{v[31]}});
  endfunction

  // ==========================================
  // multiplier hookup
  frac_multiplier u_mul
  (
    .mul (mul.calc)
  );

  assign mul.opA = operandOf(st_r, src1Sel);
  assign mul.opB = operandOf(st_r, src2Sel);
  // negation honoured only when nothing moves in parallel
  assign mul.negate = negate & isNone;

  // ==========================================
  // move decode
  assign isNone      = (moveKind == sfm_pkg::MOVE_NONE);
  assign isSingle    = (moveKind == sfm_pkg::MOVE_SINGLE);
  // dual reads suppressed while running from data memory
  assign isDual      = (moveKind == sfm_pkg::MOVE_DUAL) & ~executeFromDataMemory;
  assign singleWrite = issue & isSingle & ~singleIsRead;

  // store source, limited when its extension is in use
  always_comb
  begin
    moveAcc = st_r.acc[0];
    limited = {1'b0, operandOf(st_r, singleSrc + 3'h3)};
    case (singleSrc)
      sfm_pkg::DST_A, sfm_pkg::DST_B, sfm_pkg::DST_C:
      begin
        moveAcc = st_r.acc[singleSrc[1:0]];
        if (extInUse(moveAcc))
          limited = {1'b1, moveAcc[35] ? sfm_pkg::SAT_NEG : sfm_pkg::SAT_POS};
        else
          limited = {1'b0, moveAcc[31:16]};
      end
      sfm_pkg::DST_X0: limited = {1'b0, st_r.x0};
      sfm_pkg::DST_Y0: limited = {1'b0, st_r.y0};
      sfm_pkg::DST_Y1: limited = {1'b0, st_r.y1};
      default:         limited = {1'b0, sfm_pkg::WORD_RESET};
    endcase
  end

  // ==========================================
  // memory side outputs
  assign memAddr0  = st_r.ptr[slot0Ptr];
  assign memAddr1  = st_r.ptr[slot1Ptr];
  assign memRdEn0  = issue & ((isSingle & singleIsRead) | isDual);
  assign memRdEn1  = issue & isDual;
  assign memWrEn   = singleWrite;
  assign memWrData = limited[15:0];

  // ==========================================
  // next state: reads first, multiply result last so it wins a conflict
  always_comb
  begin
    st_nxt = st_r;
    view   = mul.product;
    if (issue)
    begin
      // parallel reads and post-modify, same cycle as the multiply
      if ((isSingle & singleIsRead) | isDual)
      begin
        st_nxt = loadWord(st_nxt, slot0Dst, slot0RdData);
        st_nxt.ptr[slot0Ptr] = st_r.ptr[slot0Ptr] + slot0Step;
      end
      if (singleWrite)
        st_nxt.ptr[slot0Ptr] = st_r.ptr[slot0Ptr] + slot0Step;
      if (isDual)
      begin
        st_nxt = loadWord(st_nxt, slot1Dst, slot1RdData);
        st_nxt.ptr[slot1Ptr] = st_r.ptr[slot1Ptr] + slot1Step;
      end
      // result overwrites destination, old contents unused
      case (dstSel)
        sfm_pkg::DST_A, sfm_pkg::DST_B, sfm_pkg::DST_C:
          st_nxt.acc[dstSel[1:0]] = mul.product;
        sfm_pkg::DST_X0, sfm_pkg::DST_Y0, sfm_pkg::DST_Y1:
        begin
          st_nxt = loadWord(st_nxt, dstSel, mul.product[31:16]);
          view   = {{4{mul.product[31]}}, mul.product[31:16], sfm_pkg::LOW_CLEAR};
        end
        default:
          st_nxt = st_nxt;
      endcase
      // condition codes from the result
      st_nxt.cc[sfm_pkg::CC_E] = extInUse(view);
      st_nxt.cc[sfm_pkg::CC_N] = view[35];
      st_nxt.cc[sfm_pkg::CC_Z] = (view == sfm_pkg::ACC_RESET);
      st_nxt.cc[sfm_pkg::CC_V] = 1'b0;
      st_nxt.cc[sfm_pkg::CC_U] = ~(view[31] ^ view[30]);
      // sticky move flags
      if (singleWrite & limited[16])
        st_nxt.cc[sfm_pkg::CC_L] = 1'b1;
      if (singleWrite & (singleSrc <= sfm_pkg::DST_C) & (moveAcc[30] ^ moveAcc[29]))
        st_nxt.cc[sfm_pkg::CC_SZ] = 1'b1;
    end
    // synchronous reset
    if (!reset_n)
    begin
      st_nxt.acc = {3{sfm_pkg::ACC_RESET}};
      st_nxt.x0  = sfm_pkg::WORD_RESET;
      st_nxt.y0  = sfm_pkg::WORD_RESET;
      st_nxt.y1  = sfm_pkg::WORD_RESET;
      st_nxt.ptr = {sfm_pkg::PTR_N{sfm_pkg::WORD_RESET}};
      st_nxt.cc  = sfm_pkg::CC_RESET;
    end
  end

  // state register, one instruction per edge
  always_ff @(posedge clk)
  begin
    st_r <= st_nxt;
  end

  // ==========================================
  // register views
  assign accA           = st_r.acc[0];
  assign accB           = st_r.acc[1];
  assign accC           = st_r.acc[2];
  assign firstOperand   = st_r.x0;
  assign secondOperand  = st_r.y0;
  assign thirdOperand   = st_r.y1;
  assign conditionCodes = st_r.cc;

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_ovf_cleared: assert property (issue |=> !conditionCodes[sfm_pkg::CC_V])
    else $error("overflow flag not cleared");
  a_acc_result: assert property (issue && dstSel == sfm_pkg::DST_A && !isDual
      |=> accA == $past(mul.product))
    else $error("accumulator a does not hold product");
  a_word_high: assert property (issue && dstSel == sfm_pkg::DST_X0 && isNone
      |=> firstOperand == $past(mul.product[31:16]))
    else $error("word destination not upper half");
  a_neg_flag: assert property (issue && dstSel == sfm_pkg::DST_B
      |=> conditionCodes[sfm_pkg::CC_N] == accB[35])
    else $error("negative flag wrong");
  a_zero_flag: assert property (issue && dstSel == sfm_pkg::DST_C
      |=> conditionCodes[sfm_pkg::CC_Z] == (accC == sfm_pkg::ACC_RESET))
    else $error("zero flag wrong");
  a_ext_flag: assert property (issue && dstSel == sfm_pkg::DST_A
      |=> conditionCodes[sfm_pkg::CC_E] == extInUse(accA))
    else $error("extension flag wrong");
  a_read_load: assert property (issue && isDual && slot1Dst == sfm_pkg::DST_X0
      && dstSel != sfm_pkg::DST_X0 |=> firstOperand == $past(slot1RdData))
    else $error("parallel read not loaded");
  a_ptr_step: assert property (issue && isDual && slot0Ptr != slot1Ptr
      |=> st_r.ptr[$past(slot0Ptr)] == $past(memAddr0) + $past(slot0Step))
    else $error("pointer not post-modified");
  a_limit_set: assert property (singleWrite && limited[16]
      |=> conditionCodes[sfm_pkg::CC_L])
    else $error("limit flag not set");
  a_neg_gated: assert property (!isNone |-> !mul.negate)
    else $error("negation with parallel move");
  a_dual_gated: assert property (executeFromDataMemory |-> !memRdEn1)
    else $error("dual read while executing from data memory");

endmodule

// [frac_mem_model.sv]
// data memory model for the parallel moves of the multiply datapath
// assumes same-cycle reads, writes taken on the rising clock edge
`timescale 1ns/1ps

module frac_mem_model
(
  input  wire logic        clk,
  input  wire logic [15:0] addr0,
  input  wire logic [15:0] addr1,
  input  wire logic        rdEn0,
  input  wire logic        rdEn1,
  input  wire logic        wrEn,
  input  wire logic [15:0] wrData,
  output logic [15:0]      rdData0,
  output logic [15:0]      rdData1
);
  // ==========================================
  // storage
  logic [15:0] mem [0:511];                  // word array, low address bits
  logic        toggle_r = 1'b0;              // flips each cycle for junk

  initial
  begin
    foreach (mem[i]) mem[i] = 16'h0;
  end

  // ==========================================
  // reads answer in the issue cycle; idle ports show changing junk
  assign rdData0 = rdEn0 ? mem[addr0[8:0]] : {8{toggle_r, ~toggle_r}};
  assign rdData1 = rdEn1 ? mem[addr1[8:0]] : {8{~toggle_r, toggle_r}};

  // write port, one word per cycle
  always @(posedge clk)
  begin
    toggle_r <= ~toggle_r;
    if (wrEn)
      mem[addr0[8:0]] <= wrData;
  end
endmodule

// [test_signed_fractional_multiply_unit.sv]
// self-checking bench for the signed fractional multiply datapath
// assumes the memory model answers reads in the cycle of issue
`timescale 1ns/1ps

module test_signed_fractional_multiply_unit;
  // ==========================================
  // stimulus and bookkeeping
  typedef struct packed
  {
    logic [15:0] a;                          // loaded into first operand
    logic [15:0] b;                          // loaded into second operand
    logic [2:0]  d;                          // destination code
    logic        ng;                         // negated form
    logic [35:0] exp;                        // expected full product
  } row_t;
  logic clk = 1'b0, reset_n = 1'b0, issue = 1'b0, negate = 1'b0, singleIsRead = 1'b0;
  logic executeFromDataMemory = 1'b0, memRdEn0, memRdEn1, memWrEn;
  logic [2:0] src1Sel = 3'h0, src2Sel = 3'h0, dstSel = 3'h6, singleSrc = 3'h0, slot0Ptr = 3'h0;
  logic [2:0] slot0Dst = 3'h0, slot1Ptr = 3'h3, slot1Dst = sfm_pkg::DST_X0;
  logic [15:0] slot0Step = 16'h0, slot1Step = 16'h0, slot0RdData, slot1RdData;
  logic [15:0] memAddr0, memAddr1, memWrData, firstOperand, secondOperand, thirdOperand;
  logic [35:0] accA, accB, accC;
  logic [7:0] conditionCodes;
  sfm_pkg::move_kind_t moveKind = sfm_pkg::MOVE_NONE;
  int miscompares = 0, samplesChecked = 0, cycles = 0;
  logic [15:0] ep0 = 16'h0, ep3 = 16'h0;     // expected pointer values
  logic [35:0] res;                          // expected destination view
  row_t rows [7] = '{
    '{16'h02a0, 16'h0200, sfm_pkg::DST_A, 1'b0, 36'h0_000a_8000},
    '{16'h8000, 16'h8000, sfm_pkg::DST_A, 1'b0, 36'h0_8000_0000},
    '{16'h8000, 16'h4000, sfm_pkg::DST_B, 1'b0, 36'hf_c000_0000},
    '{16'h4000, 16'h4000, sfm_pkg::DST_C, 1'b1, 36'hf_e000_0000},
    '{16'h0000, 16'h1234, sfm_pkg::DST_B, 1'b0, 36'h0_0000_0000},
    '{16'h7fff, 16'h7fff, sfm_pkg::DST_Y1, 1'b0, 36'h0_7ffe_0002},
    '{16'h4000, 16'h4000, sfm_pkg::DST_A, 1'b0, 36'h0_2000_0000}};

  signed_fractional_multiply_unit dut
  (
    .clk(clk), .reset_n(reset_n), .issue(issue), .src1Sel(src1Sel), .src2Sel(src2Sel),
    .dstSel(dstSel), .negate(negate), .moveKind(moveKind), .singleIsRead(singleIsRead),
    .singleSrc(singleSrc), .executeFromDataMemory(executeFromDataMemory), .slot0Ptr(slot0Ptr),
    .slot0Step(slot0Step), .slot0Dst(slot0Dst), .slot0RdData(slot0RdData), .slot1Ptr(slot1Ptr),
    .slot1Step(slot1Step), .slot1Dst(slot1Dst), .slot1RdData(slot1RdData), .memAddr0(memAddr0),
    .memAddr1(memAddr1), .memRdEn0(memRdEn0), .memRdEn1(memRdEn1), .memWrEn(memWrEn),
    .memWrData(memWrData), .accA(accA), .accB(accB), .accC(accC), .firstOperand(firstOperand),
    .secondOperand(secondOperand), .thirdOperand(thirdOperand), .conditionCodes(conditionCodes)
  );

  frac_mem_model model
  (
    .clk(clk), .addr0(memAddr0), .addr1(memAddr1), .rdEn0(memRdEn0), .rdEn1(memRdEn1),
    .wrEn(memWrEn), .wrData(memWrData), .rdData0(slot0RdData), .rdData1(slot1RdData)
  );

  // ==========================================
  // clock and hang guard
  initial
  begin
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 1000)
    begin
      miscompares++;
      finalReport();
    end
  end

  // ==========================================
  // helpers
  // compare one value, count it, report a mismatch
  task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // flags expected from a 36-bit result; sticky limit and size given
  function automatic logic [7:0] flags(input logic [35:0] r, input logic l, input logic sz);
    logic e;
    e = !((&r[35:31]) || !(|r[35:31]));
    return {sz, l, e, !(r[31] ^ r[30]), r[35], r == 36'h0, 2'b00};
  endfunction

  // destination seen as a 36-bit value; words sit in the middle
  function automatic logic [35:0] view(input logic [2:0] d);
    case (d)
      sfm_pkg::DST_A:  return accA;
      sfm_pkg::DST_B:  return accB;
      sfm_pkg::DST_C:  return accC;
      sfm_pkg::DST_X0: return {{4{firstOperand[15]}}, firstOperand, 16'h0};
      sfm_pkg::DST_Y0: return {{4{secondOperand[15]}}, secondOperand, 16'h0};
      default:         return {{4{thirdOperand[15]}}, thirdOperand, 16'h0};
    endcase
  endfunction

  // present one instruction; returns inside its issue cycle
  task automatic drive(input logic [2:0] s1, s2, d, input logic ng, input sfm_pkg::move_kind_t mk,
                       input logic rd, input logic [2:0] ss, p0, d0, input logic [15:0] st0, st1);
    @(posedge clk);
    {src1Sel, src2Sel, dstSel, negate} <= {s1, s2, d, ng};
    moveKind <= mk;
    {singleIsRead, singleSrc, slot0Ptr, slot0Dst} <= {rd, ss, p0, d0};
    {slot0Step, slot1Step, issue} <= {st0, st1, 1'b1};
    #1;
  endtask

  // let the design take the instruction, then settle
  task automatic take();
    @(posedge clk);
    issue <= 1'b0;
    #1;
  endtask

  // dual read fills first and second operands
  task automatic load(input logic [15:0] a, b);
    model.mem[ep3[8:0]] = a;
    model.mem[ep0[8:0]] = b;
    drive(sfm_pkg::SRC_X0, sfm_pkg::SRC_Y0, 3'h6, 1'b0, sfm_pkg::MOVE_DUAL, 1'b0, 3'h0, 3'h0,
          sfm_pkg::DST_Y0, 16'h0001, 16'h0001);
    cmp(memAddr0, ep0);
    cmp(memAddr1, ep3);
    cmp(memRdEn1, 1'b1);
    take();
    cmp(firstOperand, a);
    cmp(secondOperand, b);
    ep0 = ep0 + 16'h1;
    ep3 = ep3 + 16'h1;
  endtask

  task automatic finalReport();
    if (miscompares == 0 && samplesChecked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    // move the second pointer away by a long step
    drive(3'h0, 3'h0, 3'h6, 1'b0, sfm_pkg::MOVE_DUAL, 1'b0, 3'h0, 3'h0, sfm_pkg::DST_Y0, 16'h0, 16'h0100);
    take();
    ep3 = 16'h0100;
    // ordinary products, one per row, over stale destinations
    foreach (rows[i])
    begin
      load(rows[i].a, rows[i].b);
      drive(sfm_pkg::SRC_X0, sfm_pkg::SRC_Y0, rows[i].d, rows[i].ng, sfm_pkg::MOVE_NONE, 1'b0, 3'h0, 3'h0,
            3'h0, 16'h0, 16'h0);
      take();
      res = rows[i].d < sfm_pkg::DST_X0 ? rows[i].exp : {{4{rows[i].exp[31]}}, rows[i].exp[31:16], 16'h0};
      cmp(view(rows[i].d), res);
      cmp(conditionCodes, flags(res, 1'b0, 1'b0));
    end
    // accumulator middle word as a source, with an unlimited store of a that sets size
    drive(sfm_pkg::SRC_A1, sfm_pkg::SRC_Y0, sfm_pkg::DST_B, 1'b0, sfm_pkg::MOVE_SINGLE, 1'b0,
          sfm_pkg::DST_A, 3'h5, 3'h0, 16'h0, 16'h0);
    cmp(memWrEn, 1'b1);
    cmp(memWrData, 16'h2000);
    take();
    cmp(accB, 36'h0_1000_0000);
    cmp(conditionCodes, flags(36'h0_1000_0000, 1'b0, 1'b1));
    // saturating single write while negate is requested and ignored
    load(16'h8000, 16'h8000);
    drive(sfm_pkg::SRC_X0, sfm_pkg::SRC_Y0, sfm_pkg::DST_A, 1'b0, sfm_pkg::MOVE_NONE, 1'b0, 3'h0, 3'h0,
          3'h0, 16'h0, 16'h0);
    take();
    drive(sfm_pkg::SRC_X0, sfm_pkg::SRC_Y0, sfm_pkg::DST_B, 1'b1, sfm_pkg::MOVE_SINGLE, 1'b0,
          sfm_pkg::DST_A, 3'h5, 3'h0, 16'h0001, 16'h0);
    cmp(memWrEn, 1'b1);
    cmp(memWrData, sfm_pkg::SAT_POS);
    cmp(memAddr0, 16'h0);
    take();
    cmp(accB, 36'h0_8000_0000);
    cmp(conditionCodes, flags(36'h0_8000_0000, 1'b1, 1'b1));
    cmp(model.mem[0], sfm_pkg::SAT_POS);
    // single read with a backward step, while executing from data memory
    @(posedge clk);
    executeFromDataMemory <= 1'b1;
    model.mem[1] = 16'h1357;
    drive(sfm_pkg::SRC_X0, sfm_pkg::SRC_Y0, sfm_pkg::DST_C, 1'b0, sfm_pkg::MOVE_SINGLE, 1'b1, 3'h0, 3'h5,
          sfm_pkg::DST_Y1, 16'hffff, 16'h0);
    cmp(memRdEn0, 1'b1);
    cmp(memRdEn1, 1'b0);
    cmp(memAddr0, 16'h1);
    take();
    cmp(thirdOperand, 16'h1357);
    cmp(accC, 36'h0_8000_0000);
    cmp(memAddr0, 16'h0);
    // reset in mid-run clears everything
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    cmp(accA, 36'h0);
    cmp(thirdOperand, 16'h0);
    cmp(conditionCodes, sfm_pkg::CC_RESET);
    finalReport();
  end
endmodule
